// ===== rtl/clh_pkg.sv
// Shared constants, types and address helpers of the character display host port.
// Assumes a single 50 MHz system clock and an AHB-Lite register bus.
package clh_pkg;

  // ==========================================================================
  // Timing
  localparam int CLK_PERIOD_NS = 20;
  localparam int T_INSTR_NS = 39000;
  localparam int T_DATA_NS = 43000;
  localparam int T_CLEAR_NS = 1530000;
  localparam int INSTR_CYCLES = (T_INSTR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DATA_CYCLES = (T_DATA_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CLEAR_CYCLES_DEF = (T_CLEAR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int BUSY_W = 17;

  // ==========================================================================
  // Memories
  localparam int DD_ENTRIES = 80;
  localparam int CG_ENTRIES = 64;
  localparam int SEG_ENTRIES = 16;
  localparam logic [4:0] DD_LAST_COL = 5'h13;
  localparam logic [6:0] DD_COLS = 7'h14;
  localparam logic [7:0] BLANK_CHAR = 8'h20;

  // ==========================================================================
  // Instruction and serial fields
  localparam int FN_DL_BIT = 4;
  localparam int FN_RE_BIT = 2;
  localparam logic DL_RESET = 1'b1;
  localparam logic [4:0] SERIAL_SYNC = 5'h1F;
  localparam int SER_RW_BIT = 2;
  localparam int SER_RS_BIT = 1;

  // ==========================================================================
  // Register map
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam int CTRL_HOST_EN_BIT = 0;
  localparam logic CTRL_HOST_EN_RESET = 1'b1;
  localparam int STATUS_W = 11;

  typedef enum logic [1:0] {TGT_DD = 2'h0, TGT_CG = 2'h1, TGT_SEG = 2'h3} clh_target_t;
  typedef enum logic [1:0] {SER_IDLE = 2'h0, SER_SYNC = 2'h1, SER_XFER = 2'h3} clh_ser_t;

  typedef struct packed {
    logic im;
    logic rsCs;
    logic rwSid;
    logic eSclk;
    logic [7:0] db;
  } clh_pins_t;

  typedef struct packed {
    logic serialMode;
    logic re;
    logic busWidth8;
    logic busy;
    logic [6:0] ac;
  } clh_status_t;

  // Display address to linear memory index, four lines of twenty
  function automatic logic [6:0] ddIndex(input logic [6:0] a);
    ddIndex = 7'(a[6:5]) * DD_COLS + 7'(a[4:0]);
  endfunction : ddIndex

  function automatic logic ddValid(input logic [6:0] a);
    ddValid = (a[4:0] <= DD_LAST_COL);
  endfunction : ddValid

  // Step within a line, hop to the next line after the last column
  function automatic logic [6:0] ddNext(input logic [6:0] a);
    ddNext = (a[4:0] >= DD_LAST_COL) ? {a[6:5] + 2'h1, 5'h00} : a + 7'h01;
  endfunction : ddNext

endpackage : clh_pkg

// ===== rtl/clh_sync.sv
// Two-stage synchroniser for a bundle of pin inputs.
// Assumes every bit is asynchronous to sys_clk and only levels are carried.
`timescale 1ns/1ps
module clh_sync #(
  parameter int W = 12
) (
  input wire logic sys_clk, // System clock
  input wire logic rst_n, // Synchronous reset, active low
  input wire logic [W-1:0] asyncIn, // Raw pin levels
  output logic [W-1:0] syncOut // Synchronised levels
);

  logic [W-1:0] stage1;

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      stage1 <= '0;
      syncOut <= '0;
    end else begin
      stage1 <= asyncIn;
      syncOut <= stage1;
    end
  end

endmodule : clh_sync

// ===== rtl/clh_ahb_regs.sv
// AHB-Lite slave holding the control and status words of the host port.
// Assumes a single slave system, word accesses only; answers with zero wait states.
`timescale 1ns/1ps
module clh_ahb_regs
  import clh_pkg::*;
(
  input wire logic sys_clk, // System clock
  input wire logic rst_n, // Synchronous reset, active low
  input wire logic hsel, // Slave select
  input wire logic [31:0] haddr, // Byte address
  input wire logic [1:0] htrans, // Transfer type
  input wire logic hwrite, // Write when high
  input wire logic [2:0] hsize, // Transfer size
  input wire logic [31:0] hwdata, // Write data
  input wire logic hready, // Bus ready
  output logic hreadyout, // Slave ready
  output logic hresp, // Response, always OKAY
  output logic [31:0] hrdata, // Read data
  input wire clh_status_t status, // Live port state
  output logic hostEnable // Pin accesses accepted when high
);

  // ==========================================================================
  // Address phase decode
  logic wrPend;
  logic [7:0] wrAddr;
  wire addrPhase = hsel & htrans[1] & hready;
  wire [7:0] addrLow = haddr[7:0];
  wire [31:0] rdValue = (addrLow == REG_CTRL) ? {31'h0, hostEnable} :
                        (addrLow == REG_STATUS) ? {21'h0, status} : 32'h0;

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  // ==========================================================================
  // Data phase
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      wrPend <= 1'b0;
      wrAddr <= 8'h00;
      hrdata <= 32'h0;
      hostEnable <= CTRL_HOST_EN_RESET;
    end else begin
      if (wrPend && wrAddr == REG_CTRL) begin
        hostEnable <= hwdata[CTRL_HOST_EN_BIT];
      end
      wrPend <= addrPhase & hwrite;
      wrAddr <= addrLow;
      if (addrPhase && !hwrite) begin
        hrdata <= rdValue;
      end
    end
  end

endmodule : clh_ahb_regs

// ===== rtl/clh_host_port.sv
// Host port of a character display controller: pin bus/serial front end,
// command and data holding registers, address counter and display memories.
// Assumes pins are asynchronous and much slower than sys_clk; one AHB-Lite master.
// Operation
// - Interface select pin picks serial or parallel
// - Parallel width follows the bus width bit
// - Two 8-bit registers: data and command
// - Data goes to last addressed memory
// - After data read, prefetch next address
// - Data write commits to memory automatically
// - Command register is never read back
// - Select from pin, or serial select bit
// - Select/direction decode to four operations
// - Status read: busy bit 7, counter 6..0
// - While busy, further commands are ignored
// - Display memory holds eighty character bytes
// - Display address lives in address counter
// - Four lines at 00, 20, 40, 60
// - Pattern memory holds eight 5x8 characters
// - Codes 0x-0x07 map to pattern rows (code also maps 0x08-0x0F, aliased onto 0x00-0x07)
// - Select pin: data high, serial chip select
// - Bus width bit one is 8-bit
// - Narrow bus uses upper nibble, high first
//
// The AHB-Lite register port and the register addresses were decided locally.
`timescale 1ns/1ps
module clh_host_port
  import clh_pkg::*;
#(
  parameter int CLEAR_CYCLES = CLEAR_CYCLES_DEF
) (
  input wire logic sys_clk, // System clock, 50 MHz
  input wire logic rst_n, // Synchronous reset, active low
  input wire logic interfaceSelectPin, // High parallel, low serial
  input wire logic regSelectOrChipSelect, // Register select or chip select
  input wire logic readWriteOrSerialIn, // Read/write or serial data in
  input wire logic enableOrSerialClk, // Enable strobe or serial clock
  input wire logic [7:0] dataLineIn, // Data lines, input side
  output logic [7:0] dataLineOut, // Data lines, output side
  output logic [7:0] dataLineOe, // Data line drive enables
  input wire logic [7:0] glyphCode, // Display side character code
  input wire logic [2:0] glyphRow, // Display side pattern row
  output logic [7:0] glyphDots, // Pattern row dots and blink bits
  input wire logic hsel, // AHB slave select
  input wire logic [31:0] haddr, // AHB address
  input wire logic [1:0] htrans, // AHB transfer type
  input wire logic hwrite, // AHB write
  input wire logic [2:0] hsize, // AHB size
  input wire logic [31:0] hwdata, // AHB write data
  input wire logic hready, // AHB ready
  output logic hreadyout, // AHB slave ready
  output logic hresp, // AHB response
  output logic [31:0] hrdata // AHB read data
);

  if (CLEAR_CYCLES < 1 || CLEAR_CYCLES >= (1 << BUSY_W)) begin : g_bad_clear
    $error("CLEAR_CYCLES out of range");
  end

  // ==========================================================================
  // Pin synchronisation
  clh_pins_t pinRaw;
  clh_pins_t pin;
  logic clkPrev;
  logic hostEnable;

  assign pinRaw = {interfaceSelectPin, regSelectOrChipSelect, readWriteOrSerialIn,
                   enableOrSerialClk, dataLineIn};

  clh_sync #(.W($bits(clh_pins_t))) u_sync (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .asyncIn(pinRaw),
    .syncOut(pin)
  );

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      clkPrev <= 1'b0;
    end else begin
      clkPrev <= pin.eSclk;
    end
  end

  wire clkRise = pin.eSclk & ~clkPrev;
  wire clkFall = ~pin.eSclk & clkPrev;
  wire serialMode = ~pin.im;
  wire parallel = pin.im;

  // ==========================================================================
  // Core state
  logic [6:0] ac;
  logic [7:0] dr;
  logic busWidth8;
  logic re;
  clh_target_t target;
  logic [BUSY_W-1:0] busyCnt;
  logic clearing;
  logic [6:0] clearIdx;
  logic prefetch;
  logic busy;

  assign busy = (busyCnt != '0) | clearing;

  // ==========================================================================
  // Parallel front end
  logic nibblePhase;
  logic [3:0] nibbleHi;
  logic parRs;
  logic parRw;
  logic parDrive;
  logic [7:0] readHold;
  logic [7:0] parOut;

  // Serial front end
  clh_ser_t serState;
  logic [2:0] bitCnt;
  logic [6:0] shIn;
  logic [7:0] shOut;
  logic serRs;
  logic serRw;

  wire curRs = serialMode ? serRs : pin.rsCs;
  // Command register content is never a read source
  wire [7:0] readValue = curRs ? dr : {busy, ac};

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      nibblePhase <= 1'b0;
      nibbleHi <= 4'h0;
      parRs <= 1'b0;
      parRw <= 1'b0;
      parDrive <= 1'b0;
      readHold <= 8'h00;
      parOut <= 8'h00;
    end else if (!parallel) begin
      nibblePhase <= 1'b0;
      parDrive <= 1'b0;
    end else if (clkRise) begin
      parRs <= pin.rsCs;
      parRw <= pin.rwSid;
      parDrive <= pin.rwSid & hostEnable;
      if (!nibblePhase) begin
        readHold <= readValue;
      end
      if (busWidth8) begin
        parOut <= readValue;
      end else begin
        parOut <= nibblePhase ? {readHold[3:0], 4'h0} : {readValue[7:4], 4'h0};
      end
    end else if (clkFall) begin
      parDrive <= 1'b0;
      if (!busWidth8) begin
        nibblePhase <= ~nibblePhase;
        nibbleHi <= pin.db[7:4];
      end
    end
  end

  wire csActive = serialMode & ~pin.rsCs;
  wire [7:0] serByte = {shIn, pin.rwSid};

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      serState <= SER_IDLE;
      bitCnt <= 3'h0;
      shIn <= 7'h00;
      shOut <= 8'h00;
      serRs <= 1'b0;
      serRw <= 1'b0;
    end else if (!csActive) begin
      serState <= SER_IDLE;
      bitCnt <= 3'h0;
    end else begin
      unique case (serState)
        SER_IDLE: serState <= SER_SYNC;
        SER_SYNC, SER_XFER: begin
          if (clkRise) begin
            shIn <= serByte[6:0];
            bitCnt <= bitCnt + 3'h1;
            if (serState == SER_SYNC && bitCnt == 3'h7 && serByte[7:3] == SERIAL_SYNC) begin
              serRw <= serByte[SER_RW_BIT];
              serRs <= serByte[SER_RS_BIT];
              serState <= SER_XFER;
            end
          end else if (clkFall && serState == SER_XFER && serRw) begin
            shOut <= (bitCnt == 3'h0) ? readValue : {shOut[6:0], 1'b0};
          end
        end
      endcase
    end
  end

  // ==========================================================================
  // Access strobe shared by both front ends
  wire parStb = parallel & clkFall & hostEnable & (busWidth8 | nibblePhase);
  wire serStb = csActive & clkRise & hostEnable & (serState == SER_XFER) & (bitCnt == 3'h7);
  wire accStb = parStb | serStb;
  wire accRs = serialMode ? serRs : parRs;
  wire accRw = serialMode ? serRw : parRw;
  wire [7:0] parByte = busWidth8 ? pin.db : {nibbleHi, pin.db[7:4]};
  wire [7:0] accData = serialMode ? serByte : parByte;

  wire instrOk = accStb & ~accRs & ~accRw & ~busy;
  wire dataWr = accStb & accRs & ~accRw;
  wire dataRd = accStb & accRs & accRw;

  // ==========================================================================
  // Memories
  logic [7:0] ddMem [DD_ENTRIES];
  logic [7:0] cgMem [CG_ENTRIES];
  logic [7:0] segMem [SEG_ENTRIES];

  wire [6:0] ddIdx = ddIndex(ac);
  wire ddOk = ddValid(ac);
  wire [7:0] ddRd = ddOk ? ddMem[ddIdx] : BLANK_CHAR;
  wire [7:0] memRdData = (target == TGT_DD) ? ddRd :
                         (target == TGT_CG) ? cgMem[ac[5:0]] : segMem[ac[3:0]];
  wire [6:0] cgNext = {1'b0, ac[5:0] + 6'h01};
  wire [6:0] segNext = {3'h0, ac[3:0] + 4'h1};
  wire [6:0] acNext = (target == TGT_DD) ? ddNext(ac) :
                      (target == TGT_CG) ? cgNext : segNext;

  always_ff @(posedge sys_clk) begin
    if (clearing) begin
      ddMem[clearIdx] <= BLANK_CHAR;
    end else if (dataWr) begin
      unique case (target)
        TGT_DD: if (ddOk) ddMem[ddIdx] <= accData;
        TGT_CG: cgMem[ac[5:0]] <= accData;
        TGT_SEG: segMem[ac[3:0]] <= accData;
      endcase
    end
  end

  // Pattern fetch for the display scan
  wire userCode = (glyphCode[7:4] == 4'h0);

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      glyphDots <= 8'h00;
    end else begin
      glyphDots <= userCode ? cgMem[{glyphCode[2:0], glyphRow}] : 8'h00;
    end
  end

  // ==========================================================================
  // Command execution and data register
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      ac <= 7'h00;
      dr <= 8'h00;
      busWidth8 <= DL_RESET;
      re <= 1'b0;
      target <= TGT_DD;
      busyCnt <= '0;
      clearing <= 1'b0;
      clearIdx <= 7'h00;
      prefetch <= 1'b0;
    end else begin
      prefetch <= 1'b0;
      if (busyCnt != '0) begin
        busyCnt <= busyCnt - 1'b1;
      end
      if (clearing) begin
        clearIdx <= clearIdx + 7'h01;
        if (clearIdx == 7'(DD_ENTRIES - 1)) begin
          clearing <= 1'b0;
        end
      end
      if (prefetch) begin
        dr <= memRdData;
      end
      if (instrOk) begin
        busyCnt <= BUSY_W'(INSTR_CYCLES);
        unique casez (accData)
          8'b1???????: begin
            if (!re) begin
              target <= TGT_DD;
              ac <= accData[6:0];
              prefetch <= 1'b1;
            end
          end
          8'b01??????: begin
            target <= re ? TGT_SEG : TGT_CG;
            ac <= re ? {3'h0, accData[3:0]} : {1'b0, accData[5:0]};
            prefetch <= 1'b1;
          end
          8'b001?????: begin
            busWidth8 <= accData[FN_DL_BIT];
            re <= accData[FN_RE_BIT];
          end
          8'b0000001?: begin
            if (!re) begin
              target <= TGT_DD;
              ac <= 7'h00;
              busyCnt <= BUSY_W'(CLEAR_CYCLES);
            end
          end
          8'b00000001: begin
            target <= TGT_DD;
            ac <= 7'h00;
            clearing <= 1'b1;
            clearIdx <= 7'h00;
            busyCnt <= BUSY_W'(CLEAR_CYCLES);
          end
          default: ;
        endcase
      end else if (dataWr) begin
        dr <= accData;
        ac <= acNext;
        busyCnt <= BUSY_W'(DATA_CYCLES);
      end else if (dataRd) begin
        ac <= acNext;
        prefetch <= 1'b1;
        busyCnt <= BUSY_W'(DATA_CYCLES);
      end
    end
  end

  // ==========================================================================
  // Pin drive
  wire serDrive = csActive & (serState == SER_XFER) & serRw & hostEnable;

  assign dataLineOut = serialMode ? {7'h00, shOut[7]} : parOut;
  assign dataLineOe = parDrive ? (busWidth8 ? 8'hFF : 8'hF0) :
                      serDrive ? 8'h01 : 8'h00;

  // ==========================================================================
  // Register bus
  clh_status_t status;

  assign status = '{serialMode: serialMode, re: re, busWidth8: busWidth8, busy: busy, ac: ac};

  clh_ahb_regs u_regs (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .hsel(hsel),
    .haddr(haddr),
    .htrans(htrans),
    .hwrite(hwrite),
    .hsize(hsize),
    .hwdata(hwdata),
    .hready(hready),
    .hreadyout(hreadyout),
    .hresp(hresp),
    .hrdata(hrdata),
    .status(status),
    .hostEnable(hostEnable)
  );

endmodule : clh_host_port

// ===== sim/clh_host_port_asserts.sv
// Concurrent checks on the host port pins and register bus.
// Bound to every clh_host_port; one clock, synchronous reset.
`timescale 1ns/1ps
module clh_host_port_asserts
  import clh_pkg::*;
#(
  parameter int CLEAR_CYCLES = CLEAR_CYCLES_DEF
) (
  input wire logic sys_clk, // Clock
  input wire logic rst_n, // Reset
  input wire logic interfaceSelectPin, // Mode pin
  input wire logic regSelectOrChipSelect, // Select
  input wire logic readWriteOrSerialIn, // Direction
  input wire logic enableOrSerialClk, // Strobe
  input wire logic [7:0] dataLineIn, // Lines in
  input wire logic [7:0] dataLineOut, // Lines out
  input wire logic [7:0] dataLineOe, // Enables
  input wire logic [7:0] glyphCode, // Code
  input wire logic [2:0] glyphRow, // Row
  input wire logic [7:0] glyphDots, // Dots
  input wire logic hsel, // Select
  input wire logic [31:0] haddr, // Address
  input wire logic [1:0] htrans, // Type
  input wire logic hwrite, // Write
  input wire logic [2:0] hsize, // Size
  input wire logic [31:0] hwdata, // Write data
  input wire logic hready, // Ready
  input wire logic hreadyout, // Slave ready
  input wire logic hresp, // Response
  input wire logic [31:0] hrdata // Read data
);
  // ====
  // Checks
  logic rdReq;
  assign rdReq = hsel && htrans[1] && hready && !hwrite;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  AST_BUS_OKAY: assert property (hresp == 1'b0 && hreadyout == 1'b1)
    else $error("bus answer not ready and okay");
  AST_OE_CODES: assert property (dataLineOe inside {8'h00, 8'hFF, 8'hF0, 8'h01})
    else $error("bad drive enable pattern");
  AST_OE_MODE: assert property (dataLineOe[7] |-> interfaceSelectPin)
    else $error("bus lines driven in serial mode");
  AST_OE_READ: assert property ($rose(dataLineOe[7]) |->
    enableOrSerialClk && readWriteOrSerialIn)
    else $error("drive without read strobe");
  AST_OE_DROP: assert property ($fell(enableOrSerialClk) && interfaceSelectPin
    |-> ##[1:8] !dataLineOe[7])
    else $error("drive kept after strobe fell");
  AST_OUT_STANDS: assert property ($past(dataLineOe[7], 2) && dataLineOe[7]
    |-> $stable(dataLineOut))
    else $error("read byte changed while driven");
  AST_SER_OE: assert property ($rose(dataLineOe[0]) && !dataLineOe[7]
    |-> !interfaceSelectPin && !regSelectOrChipSelect)
    else $error("serial out without chip select");
  AST_GLYPH_ZERO: assert property (glyphCode[7:4] != 4'h0 |=> glyphDots == 8'h00)
    else $error("non pattern code gave dots");
  AST_STATUS_MODE: assert property (rdReq && haddr == 32'(REG_STATUS)
    |=> hrdata[10] == !interfaceSelectPin && hrdata[31:11] == 21'h0)
    else $error("status mode bit wrong");
  AST_UNMAPPED: assert property (rdReq && haddr == 32'h8 |=> hrdata == 32'h0)
    else $error("unmapped read not zero");
endmodule : clh_host_port_asserts

bind clh_host_port clh_host_port_asserts #(.CLEAR_CYCLES(CLEAR_CYCLES)) chk_u (
  .sys_clk(sys_clk), .rst_n(rst_n), .interfaceSelectPin(interfaceSelectPin),
  .regSelectOrChipSelect(regSelectOrChipSelect), .readWriteOrSerialIn(readWriteOrSerialIn),
  .enableOrSerialClk(enableOrSerialClk), .dataLineIn(dataLineIn),
  .dataLineOut(dataLineOut), .dataLineOe(dataLineOe), .glyphCode(glyphCode),
  .glyphRow(glyphRow), .glyphDots(glyphDots), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
  .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata));

// ===== sim/clh_mpu_model.sv
// Host processor model driving the display port pins.
// Tasks are called right after a rising clock edge.
`timescale 1ns/1ps
module clh_mpu_model
  import clh_pkg::*;
(
  input wire logic sys_clk, // Clock
  output logic interfaceSelectPin, // Mode pin
  output logic regSelectOrChipSelect, // Select
  output logic readWriteOrSerialIn, // Direction or serial in
  output logic enableOrSerialClk, // Strobe or serial clock
  output logic [7:0] dataLineIn, // Resolved lines
  input wire logic [7:0] dataLineOut, // Device value
  input wire logic [7:0] dataLineOe // Device enables
);
  logic drv = 1'b0;
  logic [7:0] hostVal = 8'h00;
  logic [7:0] lastVal = 8'h00;
  initial begin
    interfaceSelectPin = 1'b1;
    regSelectOrChipSelect = 1'b1;
    readWriteOrSerialIn = 1'b0;
    enableOrSerialClk = 1'b0;
  end
  // Released lines hold the inverse of the level last driven on them
  assign dataLineIn = (dataLineOe & dataLineOut) | (~dataLineOe & (drv ? hostVal : ~lastVal));
  always @(posedge sys_clk) begin
    if (!$isunknown(dataLineOe)) begin
      lastVal <= (dataLineOe & dataLineOut) | (~dataLineOe & (drv ? hostVal : lastVal));
    end
  end

  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
  endtask : cyc

  task automatic setMode(input logic par);
    interfaceSelectPin <= par;
    regSelectOrChipSelect <= 1'b1;
    cyc(8);
  endtask : setMode

  task automatic phase(input logic rs, rw, input logic [7:0] d, output logic [7:0] r);
    regSelectOrChipSelect <= rs;
    readWriteOrSerialIn <= rw;
    hostVal <= d;
    drv <= !rw;
    cyc(2);
    enableOrSerialClk <= 1'b1;
    cyc(8);
    r = dataLineIn;
    enableOrSerialClk <= 1'b0;
    cyc(7);
    drv <= 1'b0;
    cyc(1);
  endtask : phase

  task automatic ser(input logic rs, rw, input logic [7:0] d, output logic [7:0] r);
    logic [15:0] bits;
    bits = {SERIAL_SYNC, rw, rs, 1'b0, d};
    r = 8'h00;
    regSelectOrChipSelect <= 1'b0;
    for (int i = 15; i >= 0; i--) begin
      readWriteOrSerialIn <= bits[i];
      cyc(8);
      r = {r[6:0], dataLineIn[0]};
      enableOrSerialClk <= 1'b1;
      cyc(8);
      enableOrSerialClk <= 1'b0;
    end
    cyc(8);
    regSelectOrChipSelect <= 1'b1;
    cyc(8);
  endtask : ser

  task automatic xfer(input logic rs, rw, nb, input logic [7:0] d, output logic [7:0] r);
    logic [7:0] h;
    if (!interfaceSelectPin) begin
      ser(rs, rw, d, r);
    end else if (nb) begin
      phase(rs, rw, d, h);
      phase(rs, rw, {d[3:0], d[7:4]}, r);
      r = {h[7:4], r[7:4]};
    end else begin
      phase(rs, rw, d, r);
    end
  endtask : xfer

  task automatic waitReady(input logic nb, output logic [7:0] s);
    int n;
    n = 0;
    do begin
      xfer(1'b0, 1'b1, nb, 8'h00, s);
      n++;
    end while (s[7] !== 1'b0 && n < 300);
  endtask : waitReady
endmodule : clh_mpu_model

// ===== sim/testbench.sv
// Self-checking bench of the host port against a reference model.
// Host model on the pins, bus master tasks on the register side.
`timescale 1ns/1ps
module testbench
  import clh_pkg::*;
();
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic ifSel, rsCs, rwSi, eClk, hsel, hwrite, hready, hreadyout, hresp, narrow;
  logic [7:0] dIn, dOut, dOe, glyphCode, glyphDots, s, d;
  logic [2:0] glyphRow, hsize;
  logic [1:0] htrans;
  logic [31:0] haddr, hwdata, hrdata, r;
  int fails = 0, testsRun = 0, cycles = 0, seed = 32'h80a96e23, ac = 0, tgt = 0, re = 0;
  int mem[int];
  assign hready = hreadyout;
  initial begin
    forever #10 sys_clk = ~sys_clk;
  end

  clh_host_port #(.CLEAR_CYCLES(100)) dut_u (.sys_clk(sys_clk), .rst_n(rst_n),
    .interfaceSelectPin(ifSel), .regSelectOrChipSelect(rsCs), .readWriteOrSerialIn(rwSi),
    .enableOrSerialClk(eClk), .dataLineIn(dIn), .dataLineOut(dOut), .dataLineOe(dOe),
    .glyphCode(glyphCode), .glyphRow(glyphRow), .glyphDots(glyphDots), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata));
  clh_mpu_model mpu_u (.sys_clk(sys_clk), .interfaceSelectPin(ifSel),
    .regSelectOrChipSelect(rsCs), .readWriteOrSerialIn(rwSi), .enableOrSerialClk(eClk),
    .dataLineIn(dIn), .dataLineOut(dOut), .dataLineOe(dOe));

  // ====
  // Tasks and reference model
  task automatic summarize();
    $display("checks %0d mismatches %0d", testsRun, fails);
    if (fails == 0 && testsRun > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : summarize

  task automatic chk(input string what, input logic [31:0] exp, got);
    testsRun++;
    if (got !== exp) begin
      $display("ERROR %s expected %h seen %h", what, exp, got);
      fails++;
    end
  endtask : chk

  task automatic ahb(input logic w, input logic [31:0] a, wd);
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    do @(posedge sys_clk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge sys_clk); while (hready !== 1'b1);
    r = hrdata;
  endtask : ahb

  function automatic int key();
    return tgt * 256 + ac;
  endfunction : key

  function automatic int step(input int a);
    if (tgt == 1) begin
      return (a + 1) % 64;
    end
    if (tgt == 2) begin
      return (a + 1) % 16;
    end
    return (a % 32 >= 19) ? (a / 32 + 1) % 4 * 32 : a + 1;
  endfunction : step

  task automatic cmd(input logic [7:0] c);
    mpu_u.waitReady(narrow, s);
    chk("status", {1'b0, ac[6:0]}, s);
    mpu_u.xfer(1'b0, 1'b0, narrow, c, s);
    if (c[7]) begin
      ac = c[6:0];
      tgt = 0;
    end else if (c[6]) begin
      ac = re ? c[3:0] : c[5:0];
      tgt = re ? 2 : 1;
    end else if (c == 8'h01) begin
      ac = 0;
      tgt = 0;
      mem.delete();
    end else if (c[7:5] == 3'b001) begin
      narrow = !c[4];
      re = c[2];
    end
  endtask : cmd

  task automatic dw(input logic [7:0] v);
    mpu_u.xfer(1'b1, 1'b0, narrow, v, s);
    mem[key()] = v;
    ac = step(ac);
  endtask : dw

  task automatic dr();
    mpu_u.xfer(1'b1, 1'b1, narrow, 8'h00, s);
    chk("data", mem.exists(key()) ? mem[key()] : 32'h20, s);
    ac = step(ac);
  endtask : dr

  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 90000) begin
      fails = fails + 1;
      summarize();
    end
  end

  // ====
  // Scenarios
  initial begin
    hsel = 1'b1;
    hwrite = 1'b0;
    htrans = 2'h0;
    hsize = 3'h2;
    haddr = 32'h0;
    hwdata = 32'h0;
    glyphCode = 8'h00;
    glyphRow = 3'h0;
    narrow = 1'b0;
    repeat (12) @(posedge sys_clk);
    rst_n <= 1'b1;
    // Pin levels need two edges through the synchroniser after release
    repeat (2) @(posedge sys_clk);
    ahb(1'b0, 32'(REG_STATUS), 32'h0);
    chk("reset status", 32'h100, r);
    ahb(1'b1, 32'h8, 32'hFFFFFFFF);
    ahb(1'b0, 32'h8, 32'h0);
    chk("unmapped", 32'h0, r);
    cmd(8'h92);
    mpu_u.xfer(1'b0, 1'b1, narrow, 8'h00, s);
    chk("busy", 32'h1, s[7]);
    mpu_u.xfer(1'b0, 1'b0, narrow, 8'hB0, s);
    repeat (3) begin
      d = 8'($random(seed));
      dw(d);
    end
    cmd(8'h92);
    repeat (3) dr();
    $display("test busy and lines done");
    cmd(8'h6A);
    dw(d);
    cmd(8'h6A);
    dr();
    glyphCode <= 8'h0D;
    glyphRow <= 3'h2;
    repeat (3) @(posedge sys_clk);
    chk("glyph", d, glyphDots);
    glyphCode <= 8'h15;
    repeat (3) @(posedge sys_clk);
    chk("glyph off", 32'h0, glyphDots);
    $display("test pattern done");
    cmd(8'h20);
    ahb(1'b0, 32'(REG_STATUS), 32'h0);
    chk("width", 32'h0, r[8]);
    cmd(8'hC0);
    repeat (2) dw(8'($random(seed)));
    cmd(8'hC0);
    repeat (2) dr();
    cmd(8'h30);
    $display("test narrow done");
    mpu_u.setMode(1'b0);
    ahb(1'b0, 32'(REG_STATUS), 32'h0);
    chk("serial", 32'h1, r[10]);
    cmd(8'h85);
    dw(8'($random(seed)));
    cmd(8'h85);
    dr();
    mpu_u.setMode(1'b1);
    $display("test serial done");
    cmd(8'h34);
    ahb(1'b0, 32'(REG_STATUS), 32'h0);
    chk("extension", 32'h1, r[9]);
    cmd(8'h45);
    dw(8'($random(seed)));
    cmd(8'h45);
    dr();
    cmd(8'h30);
    $display("test segment done");
    cmd(8'h01);
    cmd(8'h8A);
    dr();
    ahb(1'b1, 32'(REG_CTRL), 32'h0);
    mpu_u.xfer(1'b0, 1'b0, narrow, 8'hA0, s);
    ahb(1'b1, 32'(REG_CTRL), 32'h1);
    cmd(8'h80);
    $display("test clear and disable done");
    summarize();
  end
endmodule : testbench
